// ---- rtl/itc_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "itc_regs.svh"

module itc_capture
    import itc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        edge_input_zero,
    input  wire logic        edge_input_one,
    input  wire logic [15:0] frt_count,
    itc_cap_if.unit          cap
);

    itc_cap_state_type s_r;
    itc_cap_state_type s_nxt;

    logic [1:0]      pin;
    logic [1:0]      rise;
    logic [1:0]      fall;
    logic [7:0]      window;
    logic [3:0]      trig;
    logic [3:0][7:0] value;
    logic [3:0][1:0] gate;

    assign pin    = {edge_input_one, edge_input_zero};
    assign rise   = pin & ~s_r.prev;
    assign fall   = ~pin & s_r.prev;
    assign window = 8'(frt_count >> cap.prescale);

    // Register r: bit 0 = channel, bit 1 = falling
    for (genvar r = 0; r < 4; r++) begin : g_reg
        localparam bit CH = (r % 2) == 1;
        localparam bit FL = r >= 2;
        always_comb begin
            if (cap.wide && CH) begin
                trig[r]  = FL ? fall[0] : rise[0];
                value[r] = frt_count[15:8];
                gate[r]  = 2'(r - 1);
            end else if (cap.wide) begin
                trig[r]  = FL ? fall[0] : rise[0];
                value[r] = frt_count[7:0];
                gate[r]  = 2'(r);
            end else begin
                trig[r]  = FL ? fall[CH] : rise[CH];
                value[r] = window;
                gate[r]  = 2'(r);
            end
        end
    end

    always_comb begin
        s_nxt      = s_r;
        s_nxt.prev = pin;
        s_nxt.load = 4'h0;
        for (int r = 0; r < 4; r++) begin
            // A stale held flag only blocks while retention is on
            if (trig[r] && !(cap.hold && s_r.held[gate[r]])) begin
                s_nxt.data[r]            = value[r];
                s_nxt.held[r]            = cap.hold;
                s_nxt.load[{r[0], r[1]}] = 1'b1;
            end else if (cap.rd_clr[r]) begin
                s_nxt.held[r] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign cap.data = s_r.data;
    assign cap.load = s_r.load;

endmodule : itc_capture

`default_nettype wire

// ---- rtl/itc_interval.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "itc_regs.svh"

module itc_interval
    import itc_pkg::*;
#(
    parameter int unsigned PIT_DIV = 1
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   ce,
    itc_pit_if.timer    pit
);

    // Divider is 16 bits wide
    if (PIT_DIV < 1 || PIT_DIV > 65536) begin : g_bad_div
        $error("PIT_DIV out of range");
    end

    itc_pit_state_type s_r;
    itc_pit_state_type s_nxt;

    // Down counter with reload at terminal count
    always_comb begin
        s_nxt    = s_r;
        s_nxt.tc = 1'b0;
        if (s_r.div == 16'(PIT_DIV - 1)) begin
            s_nxt.div = 16'h0000;
            if (s_r.count == 12'h000) begin
                s_nxt.count = pit.reload;
                s_nxt.tc    = 1'b1;
            end else begin
                s_nxt.count = s_r.count - 12'h001;
            end
        end else begin
            s_nxt.div = s_r.div + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign pit.count = s_r.count;
    assign pit.tc    = s_r.tc;

endmodule : itc_interval

`default_nettype wire

// ---- rtl/itc_links.sv ----
`timescale 1ns/1ps
`default_nettype none

interface itc_pit_if;
    logic [11:0] reload;
    logic [11:0] count;
    logic        tc;
    modport timer (input reload, output count, output tc);
    modport ctrl  (output reload, input count, input tc);
endinterface : itc_pit_if

interface itc_cap_if;
    logic            hold;
    logic            wide;
    logic [2:0]      prescale;
    logic [3:0]      rd_clr;
    logic [3:0][7:0] data;
    logic [3:0]      load;
    modport unit (input hold, input wide, input prescale, input rd_clr,
                  output data, output load);
    modport ctrl (output hold, output wide, output prescale, output rd_clr,
                  input data, input load);
endinterface : itc_cap_if

`default_nettype wire

// ---- rtl/itc_pkg.sv ----
package itc_pkg;

    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] cfg;
        logic [7:0] ien;
        logic [7:0] sts;
        logic [7:0] rld_lo;
        logic [3:0] rld_hi;
        logic [3:0] cnt_hold;
        logic       irq;
    } itc_top_state_type;

    typedef struct packed {
        logic [15:0] div;
        logic [11:0] count;
        logic        tc;
    } itc_pit_state_type;

    typedef struct packed {
        logic [3:0][7:0] data;
        logic [3:0]      held;
        logic [1:0]      prev;
        logic [3:0]      load;
    } itc_cap_state_type;

endpackage : itc_pkg

// ---- rtl/itc_regs.svh ----
`ifndef ITC_REGS_SVH
`define ITC_REGS_SVH

// Register offsets
`define ITC_OFS_CAP0_RISE   8'h22
`define ITC_OFS_CAP1_RISE   8'h23
`define ITC_OFS_CAP0_FALL   8'h24
`define ITC_OFS_CAP1_FALL   8'h25
`define ITC_OFS_CNT_LO      8'h26
`define ITC_OFS_CNT_HI      8'h27
`define ITC_OFS_RLD_LO      8'h28
`define ITC_OFS_RLD_HI      8'h29
`define ITC_OFS_CFG         8'h2a
`define ITC_OFS_IEN         8'h2b
`define ITC_OFS_STS         8'h2c

// Field positions
`define ITC_CFG_HOLD_BIT    7
`define ITC_CFG_PRE_MSB     6
`define ITC_CFG_PRE_LSB     4
`define ITC_CFG_WIDE_BIT    3
`define ITC_STS_PIT_BIT     4

// Writable masks and reset values
`define ITC_CFG_MASK        8'hf8
`define ITC_IRQ_MASK        8'h1f
`define ITC_RST_BYTE        8'h00
`define ITC_RST_NIBBLE      4'h0
`define ITC_RST_COUNT       12'h000

`endif

// ---- rtl/itc_top.sv ----
// Overview of operation
// - The 12-bit interval count reads as a low byte and a high register with bits 11..8 low.
// - Reading the count low byte copies count bits 11..8 into a holding nibble.
// - Reading the count high register returns the held nibble, not the live count.
// - Reload low holds reload bits 7..0, read/write, reset to zero.
// - Reload high holds reload bits 11..8 in bits 3..0; bits 7..4 read zero.
// - Two 8-bit capture channels each have a rising-edge and a falling-edge register.
// - Configuration bit 3 combines the two channels into one 16-bit capture.
// - In combined mode channel 1 registers hold the upper capture byte.
// - Each capture register can raise an interrupt request when loaded.
// - Configuration bits 6..4 pick timer bits n+7..n for an 8-bit capture.
// - A qualifying edge loads the capture register from the free-running timer.
// - In combined mode channel 1 registers load on channel 0 input edges.
// - An enable register has one bit per capture register in bits 3..0, reset off.
// - A status bit per capture register sets on its edge and is cleared by software.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "itc_regs.svh"

module itc_top
    import itc_pkg::*;
#(
    parameter int unsigned PIT_DIV = 1
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output var  logic [7:0]  rdata,
    input  wire logic        edge_input_zero,
    input  wire logic        edge_input_one,
    input  wire logic [15:0] frt_count,
    output var  logic        irq
);

    itc_top_state_type s_r;
    itc_top_state_type s_nxt;

    itc_pit_if pit ();
    itc_cap_if cap ();

    itc_interval #(
        .PIT_DIV (PIT_DIV)
    ) u_interval (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pit   (pit)
    );

    itc_capture u_capture (
        .clk             (clk),
        .rst_n           (rst_n),
        .ce              (ce),
        .edge_input_zero (edge_input_zero),
        .edge_input_one  (edge_input_one),
        .frt_count       (frt_count),
        .cap             (cap)
    );

    assign pit.reload   = {s_r.rld_hi, s_r.rld_lo};
    assign cap.hold     = s_r.cfg[`ITC_CFG_HOLD_BIT];
    assign cap.wide     = s_r.cfg[`ITC_CFG_WIDE_BIT];
    assign cap.prescale = s_r.cfg[`ITC_CFG_PRE_MSB:`ITC_CFG_PRE_LSB];
    assign cap.rd_clr   = {rd && addr == `ITC_OFS_CAP1_FALL,
                           rd && addr == `ITC_OFS_CAP0_FALL,
                           rd && addr == `ITC_OFS_CAP1_RISE,
                           rd && addr == `ITC_OFS_CAP0_RISE};

    always_comb begin
        logic [7:0] events;
        logic [7:0] clr;
        events = {3'h0, pit.tc, cap.load};
        clr    = 8'h00;
        s_nxt  = s_r;
        s_nxt.rdata = `ITC_RST_BYTE;
        if (rd) begin
            unique case (addr)
                `ITC_OFS_CAP0_RISE: s_nxt.rdata = cap.data[0];
                `ITC_OFS_CAP1_RISE: s_nxt.rdata = cap.data[1];
                `ITC_OFS_CAP0_FALL: s_nxt.rdata = cap.data[2];
                `ITC_OFS_CAP1_FALL: s_nxt.rdata = cap.data[3];
                `ITC_OFS_CNT_LO: begin
                    s_nxt.rdata    = pit.count[7:0];
                    s_nxt.cnt_hold = pit.count[11:8];
                end
                `ITC_OFS_CNT_HI: s_nxt.rdata = {4'h0, s_r.cnt_hold};
                `ITC_OFS_RLD_LO: s_nxt.rdata = s_r.rld_lo;
                `ITC_OFS_RLD_HI: s_nxt.rdata = {4'h0, s_r.rld_hi};
                `ITC_OFS_CFG:    s_nxt.rdata = s_r.cfg;
                `ITC_OFS_IEN:    s_nxt.rdata = s_r.ien;
                `ITC_OFS_STS:    s_nxt.rdata = s_r.sts;
                default:         s_nxt.rdata = `ITC_RST_BYTE;
            endcase
        end
        if (wr) begin
            unique case (addr)
                `ITC_OFS_RLD_LO: s_nxt.rld_lo = wdata;
                `ITC_OFS_RLD_HI: s_nxt.rld_hi = wdata[3:0];
                `ITC_OFS_CFG:    s_nxt.cfg    = wdata & `ITC_CFG_MASK;
                `ITC_OFS_IEN:    s_nxt.ien    = wdata & `ITC_IRQ_MASK;
                `ITC_OFS_STS:    clr          = wdata & `ITC_IRQ_MASK;
                default: ;
            endcase
        end
        // Hardware set wins over a same-cycle clear
        s_nxt.sts = (s_r.sts & ~clr) | events;
        s_nxt.irq = |(s_nxt.sts & s_nxt.ien);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign irq   = s_r.irq;

endmodule : itc_top

`default_nettype wire

// ---- test/itc_edge_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module itc_edge_src (
    input  wire logic        clk,
    output var  logic        edge_input_zero = 1'b0,
    output var  logic        edge_input_one  = 1'b0,
    output var  logic [15:0] frt_count       = 16'h0345
);
    always @(posedge clk) begin
        frt_count <= frt_count + 16'h0001;
    end
    // Flips one pin after an edge; stamp is the timer value seen at detection
    task automatic toggle(input int ch, output logic [15:0] stamp);
        @(posedge clk);
        if (ch == 0)
            edge_input_zero <= !edge_input_zero;
        else
            edge_input_one <= !edge_input_one;
        #1 stamp = frt_count;
    endtask : toggle
endmodule : itc_edge_src
`default_nettype wire

// ---- test/itc_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module itc_properties #(
    parameter int unsigned PIT_DIV = 1
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        edge_input_zero,
    input wire logic        edge_input_one,
    input wire logic [15:0] frt_count,
    input wire logic        irq
);
    logic [7:0]  cfg_r;
    logic [4:0]  ien_r;
    logic [11:0] rld_r;
    int unsigned gap_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= 8'h00;
            ien_r <= 5'h00;
            rld_r <= 12'h000;
            gap_r <= 0;
        end else if (ce) begin
            gap_r <= (ien_r[4] && !irq) ? gap_r + 1 : 0;
            if (wr && addr == 8'h2a)
                cfg_r <= wdata & 8'hf8;
            if (wr && addr == 8'h2b)
                ien_r <= wdata[4:0];
            if (wr && addr == 8'h28)
                rld_r[7:0] <= wdata;
            if (wr && addr == 8'h29)
                rld_r[11:8] <= wdata[3:0];
        end
    end
    sequence s_hi_read;
        ce && rd && addr == 8'h27;
    endsequence
    sequence s_no_lo_read;
        !(ce && rd && addr == 8'h26);
    endsequence
    a_hi_reserved: assert property (s_hi_read |=> rdata[7:4] == 4'h0)
        else $error("count high reserved bits set");
    a_hi_held: assert property (s_hi_read ##1 s_no_lo_read ##1 s_hi_read
        |=> rdata == $past(rdata, 2)) else $error("count high nibble not held");
    a_rld_lo_back: assert property (ce && rd && addr == 8'h28
        |=> rdata == rld_r[7:0]) else $error("reload low readback wrong");
    a_rld_hi_back: assert property (ce && rd && addr == 8'h29
        |=> rdata == {4'h0, rld_r[11:8]}) else $error("reload high readback wrong");
    a_cfg_back: assert property (ce && rd && addr == 8'h2a |=> rdata == cfg_r)
        else $error("configuration readback wrong");
    a_ien_back: assert property (ce && rd && addr == 8'h2b |=> rdata == {3'h0, ien_r})
        else $error("enable readback wrong");
    a_irq_enabled: assert property (irq |-> ien_r != 5'h00)
        else $error("interrupt without enable");
    a_edge_irq: assert property (ce && ien_r[0] && !cfg_r[7] && $rose(edge_input_zero)
        |-> ##[1:3] irq) else $error("edge did not raise interrupt");
    a_pit_bound: assert property (gap_r < 4100 * PIT_DIV)
        else $error("interval interrupt missing");
endmodule : itc_properties
`default_nettype wire

// ---- test/itc_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module itc_top_bench;
    localparam int unsigned PIT_DIV = 1;
    logic        clk, rst_n, ce, wr, rd, irq, e0, e1;
    logic [7:0]  addr, wdata, rdata, v, h1, h2;
    logic [15:0] frt, s;
    logic [11:0] c1, c2;
    logic [7:0]  ra [9] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h30};
    int          err_total, n_checks;
    itc_top #(.PIT_DIV(PIT_DIV)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .edge_input_zero(e0),
        .edge_input_one(e1), .frt_count(frt), .irq(irq));
    itc_edge_src src_u (.clk(clk), .edge_input_zero(e0), .edge_input_one(e1), .frt_count(frt));
    initial clk = 1'b0;
    always #50 clk = ~clk;
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Strobe for one cycle, then take the answer in the cycle after it
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd_reg(a, v);
        chk(v, e);
    endtask : rdc
    task automatic wait_irq(input int lim);
        for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge clk);
        #1;
        chk({7'h0, irq}, 8'h01);
        if (irq !== 1'b1)
            report_and_stop();
    endtask : wait_irq
    task automatic cap(input int ch, input logic [7:0] a, input int n);
        src_u.toggle(ch, s);
        idle(3);
        s = s >> n;
        rdc(a, s[7:0]);
    endtask : cap
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        err_total = 0;
        n_checks = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i]) rdc(ra[i], 8'h00);
        $display("reset test done");
        wr_reg(8'h28, 8'h23);
        rdc(8'h28, 8'h23);
        wr_reg(8'h29, 8'hf1);
        rdc(8'h29, 8'h01);
        wr_reg(8'h22, 8'h5a);
        rdc(8'h22, 8'h00);
        idle(64);
        rd_reg(8'h26, v);
        rd_reg(8'h27, h1);
        idle(8'h30);
        rd_reg(8'h27, h2);
        rd_reg(8'h27, h2);
        chk(h2, h1);
        c1 = {h1[3:0], v};
        chk({7'h0, c1 <= 12'h123}, 8'h01);
        rd_reg(8'h26, v);
        rd_reg(8'h27, h2);
        idle(1);
        c2 = {h2[3:0], v};
        // The two low-byte reads are sampled 56 clocks apart
        chk(8'((c1 + 12'h124 - c2) % 12'h124), 8'h38);
        // Ten frozen clocks out of sixteen leave six decrements
        @(posedge clk);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        rd_reg(8'h26, v);
        rd_reg(8'h27, h2);
        c1 = {h2[3:0], v};
        chk(8'((c2 + 12'h124 - c1) % 12'h124), 8'h06);
        wr_reg(8'h2c, 8'h1f);
        wr_reg(8'h2b, 8'h10);
        wait_irq(400);
        rd_reg(8'h2c, v);
        chk(v & 8'h10, 8'h10);
        wr_reg(8'h2b, 8'h00);
        wr_reg(8'h2c, 8'h1f);
        idle(2);
        chk({7'h0, irq}, 8'h00);
        $display("interval test done");
        for (int n = 0; n < 8; n++) begin
            wr_reg(8'h2a, 8'(n << 4));
            idle(1);
            cap(0, 8'h22, n);
            cap(0, 8'h24, n);
            cap(1, 8'h23, n);
            cap(1, 8'h25, n);
        end
        rd_reg(8'h2c, v);
        chk(v & 8'h0f, 8'h0f);
        wr_reg(8'h2c, 8'h0f);
        rd_reg(8'h2c, v);
        chk(v & 8'h0f, 8'h00);
        wr_reg(8'h2b, 8'h01);
        src_u.toggle(0, s);
        wait_irq(5);
        src_u.toggle(0, s);
        wr_reg(8'h2b, 8'h00);
        wr_reg(8'h2c, 8'h1f);
        $display("capture test done");
        wr_reg(8'h2a, 8'h08);
        idle(1);
        cap(0, 8'h22, 0);
        h1 = s[15:8];
        rdc(8'h23, h1);
        src_u.toggle(1, s);
        idle(3);
        rdc(8'h23, h1);
        cap(0, 8'h24, 0);
        rdc(8'h25, s[15:8]);
        $display("combined test done");
        wr_reg(8'h2a, 8'h80);
        src_u.toggle(0, s);
        h1 = s[7:0];
        src_u.toggle(0, s);
        src_u.toggle(0, s);
        idle(3);
        rdc(8'h22, h1);
        src_u.toggle(0, s);
        cap(0, 8'h22, 0);
        $display("hold test done");
        idle(2);
        report_and_stop();
    end
endmodule : itc_top_bench
bind itc_top itc_properties #(.PIT_DIV(PIT_DIV)) chk_u (.clk(clk), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .edge_input_zero(edge_input_zero), .edge_input_one(edge_input_one),
    .frt_count(frt_count), .irq(irq));
`default_nettype wire
